// ### rtl/dual_eight_bit_pwm_timers.sv
// two 8-bit pwm timers behind an axi4-lite register slave
`timescale 1ns/1ps
module dual_eight_bit_pwm_timers (
	input  wire logic                        core_clk_i,
	input  wire logic                        rst_n_i,
	input  wire logic [pwm_pkg::ADDR_W-1:0]  s_axi_awaddr_i,
	input  wire logic                        s_axi_awvalid_i,
	output logic                             s_axi_awready_o,
	input  wire logic [31:0]                 s_axi_wdata_i,
	input  wire logic [3:0]                  s_axi_wstrb_i,
	input  wire logic                        s_axi_wvalid_i,
	output logic                             s_axi_wready_o,
	output logic [1:0]                       s_axi_bresp_o,
	output logic                             s_axi_bvalid_o,
	input  wire logic                        s_axi_bready_i,
	input  wire logic [pwm_pkg::ADDR_W-1:0]  s_axi_araddr_i,
	input  wire logic                        s_axi_arvalid_i,
	output logic                             s_axi_arready_o,
	output logic [31:0]                      s_axi_rdata_o,
	output logic [1:0]                       s_axi_rresp_o,
	output logic                             s_axi_rvalid_o,
	input  wire logic                        s_axi_rready_i,
	input  wire logic                        port_a_bit0_i,
	input  wire logic                        port_b_bit0_i,
	input  wire logic                        port_a_bit4_i,
	input  wire logic                        fast_internal_oscillator_i,
	input  wire logic                        slow_internal_oscillator_i,
	output logic                             port_b_bit2_o,
	output logic                             port_b_bit2_oe_o,
	output logic                             port_a_bit3_o,
	output logic                             port_a_bit3_oe_o,
	output logic                             port_b_bit4_o,
	output logic                             port_b_bit4_oe_o,
	output logic                             port_b_bit5_o,
	output logic                             port_b_bit5_oe_o,
	output logic                             port_b_bit6_o,
	output logic                             port_b_bit6_oe_o,
	output logic                             port_b_bit7_o,
	output logic                             port_b_bit7_oe_o
);
	typedef struct packed {
		logic [1:0][7:0] ctrl;
		logic [1:0][7:0] scale;
		logic [1:0][7:0] bound;
		logic [1:0]      count_wr;
		logic [7:0]      count_data;
		logic            awready;
		logic            aw_got;
		logic [5:0]      aw_ix;
		logic            wready;
		logic            w_got;
		logic [7:0]      wbyte;
		logic            wbyte_en;
		logic            bvalid;
		logic [1:0]      bresp;
		logic            arready;
		logic            rvalid;
		logic [1:0]      rresp;
		logic [31:0]     rdata;
		logic [1:0][2:0] pin_val;
		logic [1:0][2:0] pin_oe;
	} top_state_t;

	top_state_t                 s;
	top_state_t                 next_s;
	logic [pwm_pkg::LANES-1:0]  raw;
	logic [pwm_pkg::LANES-1:0]  rise;
	logic [pwm_pkg::LANES-1:0]  fall;
	logic [1:0]                 tick;
	logic [1:0]                 wave;
	logic [5:0]                 ar_ix;

	////////////////////////////////////////////////////////////////////////
	// input sampling

	assign raw[pwm_pkg::LN_PIN_A0] = port_a_bit0_i;
	assign raw[pwm_pkg::LN_PIN_B0] = port_b_bit0_i;
	assign raw[pwm_pkg::LN_PIN_A4] = port_a_bit4_i;
	assign raw[pwm_pkg::LN_FAST] = fast_internal_oscillator_i;
	assign raw[pwm_pkg::LN_SLOW] = slow_internal_oscillator_i;

	pin_edge_sync u_sync (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.raw_i      (raw),
		.rise_o     (rise),
		.fall_o     (fall)
	);

	////////////////////////////////////////////////////////////////////////
	// timers

	function automatic logic pick_tick(input logic [3:0] src,
			input logic [pwm_pkg::LANES-1:0] r,
			input logic [pwm_pkg::LANES-1:0] f);
		logic t;
		t = 1'b0;
		case (src)
		pwm_pkg::SRC_STOP:  t = 1'b0;
		pwm_pkg::SRC_SYS:   t = 1'b1;
		pwm_pkg::SRC_FAST:  t = r[pwm_pkg::LN_FAST];
		pwm_pkg::SRC_SLOW:  t = r[pwm_pkg::LN_SLOW];
		pwm_pkg::SRC_PIN_A0_R: t = r[pwm_pkg::LN_PIN_A0];
		pwm_pkg::SRC_PIN_A0_F: t = f[pwm_pkg::LN_PIN_A0];
		pwm_pkg::SRC_PIN_B0_R: t = r[pwm_pkg::LN_PIN_B0];
		pwm_pkg::SRC_PIN_B0_F: t = f[pwm_pkg::LN_PIN_B0];
		pwm_pkg::SRC_PIN_A4_R: t = r[pwm_pkg::LN_PIN_A4];
		pwm_pkg::SRC_PIN_A4_F: t = f[pwm_pkg::LN_PIN_A4];
		default:            t = 1'b0;
		endcase
		return t;
	endfunction

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_timer
			assign tick[g] = pick_tick(
				s.ctrl[g][pwm_pkg::SRC_HI:pwm_pkg::SRC_LO], rise, fall);

			pwm_timer_unit u_unit (
				.core_clk_i   (core_clk_i),
				.rst_n_i      (rst_n_i),
				.tick_i       (tick[g]),
				.prescale_i   (s.scale[g][pwm_pkg::PRE_HI:pwm_pkg::PRE_LO]),
				.scaler_i     (s.scale[g][pwm_pkg::SCL_HI:pwm_pkg::SCL_LO]),
				.res6_i       (s.scale[g][pwm_pkg::RES_BIT]),
				.pwm_mode_i   (s.ctrl[g][pwm_pkg::MODE_BIT]),
				.bound_i      (s.bound[g]),
				.count_wr_i   (s.count_wr[g]),
				.count_data_i (s.count_data),
				.wave_o       (wave[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// register slave and pin routing

	assign ar_ix = s_axi_araddr_i[7:2];

	always_comb begin
		logic       hit;
		logic [1:0] route;
		logic       lvl;
		hit = 1'b0;
		route = 2'h0;
		lvl = 1'b0;
		next_s = s;
		next_s.count_wr = 2'b00;
		// write address and data may arrive in either order
		if (s_axi_awvalid_i && s.awready) begin
			next_s.awready = 1'b0;
			next_s.aw_got = 1'b1;
			next_s.aw_ix = s_axi_awaddr_i[7:2];
		end
		if (s_axi_wvalid_i && s.wready) begin
			next_s.wready = 1'b0;
			next_s.w_got = 1'b1;
			next_s.wbyte = s_axi_wdata_i[7:0];
			next_s.wbyte_en = s_axi_wstrb_i[0];
		end
		if (s.aw_got && s.w_got && !s.bvalid) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			hit = 1'b1;
			if (s.wbyte_en) begin
				case (s.aw_ix)
				pwm_pkg::T2_CTRL_IX:  next_s.ctrl[0] = s.wbyte;
				pwm_pkg::T3_CTRL_IX:  next_s.ctrl[1] = s.wbyte;
				pwm_pkg::T2_SCALE_IX: next_s.scale[0] = s.wbyte;
				pwm_pkg::T3_SCALE_IX: next_s.scale[1] = s.wbyte;
				pwm_pkg::T2_BOUND_IX: next_s.bound[0] = s.wbyte;
				pwm_pkg::T3_BOUND_IX: next_s.bound[1] = s.wbyte;
				pwm_pkg::T2_COUNT_IX: next_s.count_wr[0] = 1'b1;
				pwm_pkg::T3_COUNT_IX: next_s.count_wr[1] = 1'b1;
				pwm_pkg::STATUS_IX:   hit = 1'b1;
				default:              hit = 1'b0;
				endcase
				next_s.count_data = s.wbyte;
			end
			next_s.bresp = hit ? pwm_pkg::RESP_OKAY : pwm_pkg::RESP_SLVERR;
		end
		if (s.bvalid && s_axi_bready_i) begin
			next_s.bvalid = 1'b0;
			next_s.awready = 1'b1;
			next_s.wready = 1'b1;
		end
		// write-only registers read as zero
		if (s_axi_arvalid_i && s.arready) begin
			next_s.arready = 1'b0;
			next_s.rvalid = 1'b1;
			next_s.rdata = 32'h0000_0000;
			next_s.rresp = pwm_pkg::RESP_OKAY;
			case (ar_ix)
			pwm_pkg::T2_CTRL_IX:  next_s.rdata[7:0] = s.ctrl[0];
			pwm_pkg::T3_CTRL_IX:  next_s.rdata[7:0] = s.ctrl[1];
			pwm_pkg::STATUS_IX:   next_s.rdata[1:0] = wave;
			pwm_pkg::T2_SCALE_IX, pwm_pkg::T3_SCALE_IX,
			pwm_pkg::T2_BOUND_IX, pwm_pkg::T3_BOUND_IX,
			pwm_pkg::T2_COUNT_IX, pwm_pkg::T3_COUNT_IX:
				next_s.rdata = 32'h0000_0000;
			default: next_s.rresp = pwm_pkg::RESP_SLVERR;
			endcase
		end
		if (s.rvalid && s_axi_rready_i) begin
			next_s.rvalid = 1'b0;
			next_s.arready = 1'b1;
		end
		for (int t = 0; t < 2; t++) begin
			route = s.ctrl[t][pwm_pkg::ROUTE_HI:pwm_pkg::ROUTE_LO];
			lvl = wave[t] ^ s.ctrl[t][pwm_pkg::INV_BIT];
			for (int p = 0; p < 3; p++) begin
				next_s.pin_oe[t][p] = (route == 2'(p + 1));
				next_s.pin_val[t][p] = (route == 2'(p + 1)) && lvl;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s <= '0;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign s_axi_awready_o  = s.awready;
	assign s_axi_wready_o   = s.wready;
	assign s_axi_bvalid_o   = s.bvalid;
	assign s_axi_bresp_o    = s.bresp;
	assign s_axi_arready_o  = s.arready;
	assign s_axi_rvalid_o   = s.rvalid;
	assign s_axi_rresp_o    = s.rresp;
	assign s_axi_rdata_o    = s.rdata;
	assign port_b_bit2_o    = s.pin_val[0][0];
	assign port_b_bit2_oe_o = s.pin_oe[0][0];
	assign port_a_bit3_o    = s.pin_val[0][1];
	assign port_a_bit3_oe_o = s.pin_oe[0][1];
	assign port_b_bit4_o    = s.pin_val[0][2];
	assign port_b_bit4_oe_o = s.pin_oe[0][2];
	assign port_b_bit5_o    = s.pin_val[1][0];
	assign port_b_bit5_oe_o = s.pin_oe[1][0];
	assign port_b_bit6_o    = s.pin_val[1][1];
	assign port_b_bit6_oe_o = s.pin_oe[1][1];
	assign port_b_bit7_o    = s.pin_val[1][2];
	assign port_b_bit7_oe_o = s.pin_oe[1][2];

	////////////////////////////////////////////////////////////////////////
	// checks

	stop_source_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		s.ctrl[0][7:4] == pwm_pkg::SRC_STOP |-> !tick[0])
		else $error("stopped timer2 still ticks");

	sys_source_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		s.ctrl[1][7:4] == pwm_pkg::SRC_SYS |-> tick[1])
		else $error("system clock source does not tick every cycle");

	pin_fall_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		s.ctrl[0][7:4] == pwm_pkg::SRC_PIN_B0_F
		|-> tick[0] == fall[pwm_pkg::LN_PIN_B0])
		else $error("port_b_bit0 falling source does not follow the edge");

	route_t2_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		s.ctrl[0][3:2] == 2'h2 |=> port_a_bit3_oe_o && !port_b_bit2_oe_o
			&& !port_b_bit4_oe_o)
		else $error("timer2 route 10 does not drive port_a_bit3 alone");

	route_t3_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		s.ctrl[1][3:2] == 2'h3 |=> port_b_bit7_oe_o && !port_b_bit5_oe_o
			&& !port_b_bit6_oe_o)
		else $error("timer3 route 11 does not drive port_b_bit7 alone");

	invert_t2_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		s.ctrl[0][3:2] == 2'h1 |=> port_b_bit2_o ==
			($past(wave[0]) ^ $past(s.ctrl[0][0])))
		else $error("timer2 pin level ignores inversion");

	invert_t3_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		s.ctrl[1][3:2] == 2'h2 |=> port_b_bit6_o ==
			($past(wave[1]) ^ $past(s.ctrl[1][0])))
		else $error("timer3 pin level ignores inversion");

	count_unreadable_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(s_axi_arvalid_i && s.arready && ar_ix == pwm_pkg::T2_COUNT_IX)
		|=> s.rvalid && s.rdata == 32'h0000_0000)
		else $error("timer2 counter read back a value");

	bound_write_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(s.aw_got && s.w_got && !s.bvalid && s.wbyte_en
			&& s.aw_ix == pwm_pkg::T2_BOUND_IX)
		|=> s.bound[0] == $past(s.wbyte) && s.bvalid)
		else $error("timer2 bound write not stored");
endmodule

// ### rtl/pin_edge_sync.sv
// two-flop synchroniser with rise and fall pulses per lane
`timescale 1ns/1ps
module pin_edge_sync (
	input  wire logic                       core_clk_i,
	input  wire logic                       rst_n_i,
	input  wire logic [pwm_pkg::LANES-1:0]  raw_i,
	output logic      [pwm_pkg::LANES-1:0]  rise_o,
	output logic      [pwm_pkg::LANES-1:0]  fall_o
);
	typedef struct packed {
		logic [pwm_pkg::LANES-1:0] meta;
		logic [pwm_pkg::LANES-1:0] sync;
		logic [pwm_pkg::LANES-1:0] last;
		logic [pwm_pkg::LANES-1:0] rise;
		logic [pwm_pkg::LANES-1:0] fall;
		logic [1:0]                warm;
	} sync_state_t;

	sync_state_t s;
	sync_state_t next_s;
	logic        armed;

	always_comb begin
		next_s = s;
		next_s.meta = raw_i;
		next_s.sync = s.meta;
		next_s.last = s.sync;
		// last holds no real sample until warm saturates: no false edge
		armed = (s.warm == pwm_pkg::SYNC_WARM);
		next_s.warm = armed ? s.warm : s.warm + 2'h1;
		next_s.rise = armed ? (s.sync & ~s.last) : '0;
		next_s.fall = armed ? (~s.sync & s.last) : '0;
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign rise_o = s.rise;
	assign fall_o = s.fall;
endmodule

// ### rtl/pwm_pkg.sv
// constants shared by the dual 8-bit timer block
package pwm_pkg;
	localparam int          ADDR_W      = 8;
	// register indices; byte address is four times the index
	localparam logic [5:0]  T2_BOUND_IX = 6'h09;
	localparam logic [5:0]  T3_BOUND_IX = 6'h23;
	localparam logic [5:0]  T3_CTRL_IX  = 6'h2E;
	localparam logic [5:0]  T3_COUNT_IX = 6'h2F;
	localparam logic [5:0]  T2_SCALE_IX = 6'h37;
	localparam logic [5:0]  T3_SCALE_IX = 6'h39;
	localparam logic [5:0]  T2_CTRL_IX  = 6'h3C;
	localparam logic [5:0]  T2_COUNT_IX = 6'h3D;
	localparam logic [5:0]  STATUS_IX   = 6'h3F;
	// control register fields
	localparam int          SRC_HI      = 7;
	localparam int          SRC_LO      = 4;
	localparam int          ROUTE_HI    = 3;
	localparam int          ROUTE_LO    = 2;
	localparam int          MODE_BIT    = 1;
	localparam int          INV_BIT     = 0;
	// scaling register fields
	localparam int          RES_BIT     = 7;
	localparam int          PRE_HI      = 6;
	localparam int          PRE_LO      = 5;
	localparam int          SCL_HI      = 4;
	localparam int          SCL_LO      = 0;
	localparam logic [7:0]  REG_RESET   = 8'h00;
	// count clock sources
	localparam logic [3:0]  SRC_STOP    = 4'h0;
	localparam logic [3:0]  SRC_SYS     = 4'h1;
	localparam logic [3:0]  SRC_FAST    = 4'h2;
	localparam logic [3:0]  SRC_SLOW    = 4'h4;
	localparam logic [3:0]  SRC_PIN_A0_R = 4'h8;
	localparam logic [3:0]  SRC_PIN_A0_F = 4'h9;
	localparam logic [3:0]  SRC_PIN_B0_R = 4'hA;
	localparam logic [3:0]  SRC_PIN_B0_F = 4'hB;
	localparam logic [3:0]  SRC_PIN_A4_R = 4'hC;
	localparam logic [3:0]  SRC_PIN_A4_F = 4'hD;
	// sampled input lanes
	localparam int          LANES       = 5;
	localparam int          LN_PIN_A0   = 0;
	localparam int          LN_PIN_B0   = 1;
	localparam int          LN_PIN_A4   = 2;
	localparam int          LN_FAST     = 3;
	localparam int          LN_SLOW     = 4;
	// cycles after reset before edge pulses are trusted
	localparam logic [1:0]  SYNC_WARM   = 2'h3;
	// prescaler terminal counts for divide by 1, 4, 16, 64
	localparam logic [5:0]  PRE_DIV1    = 6'h00;
	localparam logic [5:0]  PRE_DIV4    = 6'h03;
	localparam logic [5:0]  PRE_DIV16   = 6'h0F;
	localparam logic [5:0]  PRE_DIV64   = 6'h3F;
	localparam logic [7:0]  TOP_8BIT    = 8'hFF;
	localparam logic [7:0]  TOP_6BIT    = 8'h3F;
	localparam logic [1:0]  ROUTE_OFF   = 2'h0;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// ### rtl/pwm_timer_unit.sv
// one 8-bit timer: prescaler, scaler, counter and waveform
`timescale 1ns/1ps
module pwm_timer_unit (
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        tick_i,
	input  wire logic [1:0]  prescale_i,
	input  wire logic [4:0]  scaler_i,
	input  wire logic        res6_i,
	input  wire logic        pwm_mode_i,
	input  wire logic [7:0]  bound_i,
	input  wire logic        count_wr_i,
	input  wire logic [7:0]  count_data_i,
	output logic             wave_o
);
	typedef struct packed {
		logic [5:0] pre_cnt;
		logic [4:0] scl_cnt;
		logic [7:0] count;
		logic       wave;
	} unit_state_t;

	unit_state_t s;
	unit_state_t next_s;
	logic [5:0]  pre_top;
	logic [7:0]  cnt_top;
	logic        pre_done;
	logic        step;

	always_comb begin
		case (prescale_i)
		2'h0: pre_top = pwm_pkg::PRE_DIV1;
		2'h1: pre_top = pwm_pkg::PRE_DIV4;
		2'h2: pre_top = pwm_pkg::PRE_DIV16;
		default: pre_top = pwm_pkg::PRE_DIV64;
		endcase
		cnt_top = res6_i ? pwm_pkg::TOP_6BIT : pwm_pkg::TOP_8BIT;
		pre_done = tick_i && (s.pre_cnt >= pre_top);
		step = pre_done && (s.scl_cnt >= scaler_i);
		next_s = s;
		if (tick_i) begin
			next_s.pre_cnt = pre_done ? 6'h00 : s.pre_cnt + 6'h01;
		end
		if (pre_done) begin
			next_s.scl_cnt = step ? 5'h00 : s.scl_cnt + 5'h01;
		end
		if (count_wr_i) begin
			next_s.count = count_data_i;
		end else if (step) begin
			if (!pwm_mode_i && s.count == bound_i) begin
				next_s.count = 8'h00;
			end else if (s.count >= cnt_top) begin
				next_s.count = 8'h00;
			end else begin
				next_s.count = s.count + 8'h01;
			end
		end
		if (pwm_mode_i) begin
			next_s.wave = s.count < (bound_i & cnt_top);
		end else if (step && s.count == bound_i) begin
			next_s.wave = ~s.wave;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign wave_o = s.wave;

	count_load_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		count_wr_i |=> s.count == $past(count_data_i))
		else $error("counter did not take the written value");

	pwm_level_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		pwm_mode_i |=> s.wave == ($past(s.count) < ($past(bound_i)
			& ($past(res6_i) ? pwm_pkg::TOP_6BIT : pwm_pkg::TOP_8BIT))))
		else $error("pwm level does not follow count below bound");

	period_toggle_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(!pwm_mode_i && step && s.count == bound_i && !count_wr_i)
		|=> s.wave != $past(s.wave) && s.count == 8'h00)
		else $error("period match did not toggle and restart");

	wrap_6bit_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(res6_i && step && !count_wr_i && s.count == pwm_pkg::TOP_6BIT)
		|=> s.count == 8'h00)
		else $error("6-bit count did not wrap at 63");
endmodule

// ### tb/pin_receiver_model.sv
// board side model: pins that receive the timer waveforms
`timescale 1ns/1ps
module pin_receiver_model (
	input  wire logic        core_clk_i,
	input  wire logic [5:0]  pin_i,
	input  wire logic [5:0]  oe_i,
	input  wire logic [2:0]  sel_i,
	input  wire logic        clr_i,
	output logic      [15:0] high_cnt_o
);
	logic [5:0] level;
	// an undriven pin sits at its pull-down level
	assign level = pin_i & oe_i;
	// counts high cycles on the watched pin since the last clear
	always @(posedge core_clk_i) begin
		if (clr_i) begin
			high_cnt_o <= 16'h0000;
		end else begin
			high_cnt_o <= high_cnt_o + {15'h0000, level[sel_i]};
		end
	end
endmodule

// ### tb/test_dual_eight_bit_pwm_timers.sv
// self-checking bench for the dual 8-bit pwm timers
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
	err_total++; $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); \
	end end
module test_dual_eight_bit_pwm_timers;
	localparam logic [1:0] OK = pwm_pkg::RESP_OKAY;
	localparam logic [1:0] ER = pwm_pkg::RESP_SLVERR;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0]  wstrb = 4'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	wire         awready, wready, bvalid, arready, rvalid;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	logic [4:0]  lanes = 5'h00;
	wire  [5:0]  pin, oe;
	logic [2:0]  sel = 3'h0;
	logic        clr = 1'b0;
	wire  [15:0] high_cnt;
	logic [31:0] seed = 32'hE309;
	int          err_total = 0, samples_checked = 0, cycles = 0;
	logic [3:0]  codes [10] = '{4'h0, 4'h2, 4'h4, 4'h8, 4'h9, 4'hA, 4'hB,
		4'hC, 4'hD, 4'hE};
	int          lns [10] = '{0, 3, 4, 0, 0, 1, 1, 2, 2, 0};

	always #25 core_clk = ~core_clk;

	dual_eight_bit_pwm_timers dut (
		.core_clk_i(core_clk), .rst_n_i(rst_n),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .port_a_bit0_i(lanes[0]),
		.port_b_bit0_i(lanes[1]), .port_a_bit4_i(lanes[2]),
		.fast_internal_oscillator_i(lanes[3]),
		.slow_internal_oscillator_i(lanes[4]),
		.port_b_bit2_o(pin[0]), .port_b_bit2_oe_o(oe[0]),
		.port_a_bit3_o(pin[1]), .port_a_bit3_oe_o(oe[1]),
		.port_b_bit4_o(pin[2]), .port_b_bit4_oe_o(oe[2]),
		.port_b_bit5_o(pin[3]), .port_b_bit5_oe_o(oe[3]),
		.port_b_bit6_o(pin[4]), .port_b_bit6_oe_o(oe[4]),
		.port_b_bit7_o(pin[5]), .port_b_bit7_oe_o(oe[5])
	);

	pin_receiver_model board (
		.core_clk_i(core_clk), .pin_i(pin), .oe_i(oe), .sel_i(sel),
		.clr_i(clr), .high_cnt_o(high_cnt)
	);

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {1'b0, s[31:1]} ^ (s[0] ? 32'hA3000000 : 32'h00000000);
	endfunction

	function automatic logic [7:0] rnd();
		seed = lfsr(seed);
		return seed[7:0];
	endfunction

	// live clock-source codes; stop and reserved codes hold the timer
	function automatic logic src_live(input logic [3:0] code);
		return code == 4'h1 || code == 4'h2 || code == 4'h4
			|| (code >= 4'h8 && code <= 4'hD);
	endfunction

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 90000) begin
			err_total++;
			tally_and_finish();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [5:0] ix, input logic [7:0] d,
		input logic [3:0] st, input logic [1:0] er);
		@(posedge core_clk);
		awaddr <= {ix, 2'b00};
		wdata <= {24'h000000, d};
		wstrb <= st;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		`CHK(bresp, er);
	endtask

	task automatic rd(input logic [5:0] ix, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge core_clk);
		araddr <= {ix, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic rdc(input logic [5:0] ix, input logic [7:0] ed,
		input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		rd(ix, d, r);
		`CHK(d, {24'h000000, ed});
		`CHK(r, er);
	endtask

	task automatic cfg(input int t, input logic [7:0] c, s, b);
		logic [5:0] cx, sx, bx, nx;
		cx = t == 2 ? pwm_pkg::T2_CTRL_IX : pwm_pkg::T3_CTRL_IX;
		sx = t == 2 ? pwm_pkg::T2_SCALE_IX : pwm_pkg::T3_SCALE_IX;
		bx = t == 2 ? pwm_pkg::T2_BOUND_IX : pwm_pkg::T3_BOUND_IX;
		nx = t == 2 ? pwm_pkg::T2_COUNT_IX : pwm_pkg::T3_COUNT_IX;
		wr(cx, 8'h00, 4'h1, OK);
		wr(sx, s, 4'h1, OK);
		wr(bx, b, 4'h1, OK);
		wr(nx, 8'h00, 4'h1, OK);
		wr(cx, c, 4'h1, OK);
		repeat (4) @(posedge core_clk);
	endtask

	// measures high cycles over one whole waveform period
	task automatic duty(input int t, input logic [7:0] c, s, b);
		int         dv, per, hi, bm;
		logic [2:0] base;
		logic [2:0] exp_oe;
		dv = (1 << (2 * s[6:5])) * (s[4:0] + 1);
		bm = s[7] ? b[5:0] : b;
		per = c[1] ? (s[7] ? 64 : 256) * dv : 2 * (b + 1) * dv;
		hi = c[1] ? bm * dv : per / 2;
		if (c[1] && c[0]) hi = per - hi;
		if (c[3:2] == 2'b00) hi = 0;
		base = t == 2 ? 3'd0 : 3'd3;
		sel <= base + (c[3:2] == 2'b00 ? 3'd0 : {1'b0, c[3:2]} - 3'd1);
		cfg(t, c, s, b);
		repeat (per) @(posedge core_clk);
		clr <= 1'b1;
		@(posedge core_clk);
		clr <= 1'b0;
		repeat (per) @(posedge core_clk);
		#1;
		`CHK(high_cnt, hi[15:0]);
		exp_oe = c[3:2] == 2'h0 ? 3'h0 : 3'h1 << (c[3:2] - 2'h1);
		`CHK(oe[base +: 3], exp_oe);
	endtask

	// period mode, bound 3: the fourth selected edge toggles the wave
	task automatic edges(input logic [3:0] code, input int ln);
		logic [31:0] d0, d;
		logic [1:0]  r;
		int          i;
		lanes[ln] <= code[0];
		cfg(2, {code, 4'h0}, 8'h00, 8'h03);
		rd(pwm_pkg::STATUS_IX, d0, r);
		for (i = 0; i < 7; i++) begin
			@(posedge core_clk);
			seed = lfsr(seed);
			lanes <= (seed[4:0] & ~(5'h01 << ln)) | ({4'h0, ~lanes[ln]} << ln);
			repeat (6) @(posedge core_clk);
			if (i == 5) begin
				rd(pwm_pkg::STATUS_IX, d, r);
				`CHK(d[0], d0[0]);
			end
		end
		rd(pwm_pkg::STATUS_IX, d, r);
		`CHK(d[0], src_live(code) ? ~d0[0] : d0[0]);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [7:0]  c, s, b, v;
		int          i;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		#1;
		`CHK(oe, 6'h00);
		rdc(pwm_pkg::T2_CTRL_IX, 8'h00, OK);
		rdc(pwm_pkg::T3_CTRL_IX, 8'h00, OK);
		wr(pwm_pkg::T3_CTRL_IX, 8'hA5, 4'h1, OK);
		rdc(pwm_pkg::T3_CTRL_IX, 8'hA5, OK);
		// strobe 0 is dropped by the slave but still answered okay
		wr(pwm_pkg::T3_CTRL_IX, 8'h3C, 4'h0, OK);
		rdc(pwm_pkg::T3_CTRL_IX, 8'hA5, OK);
		wr(6'h01, 8'hFF, 4'h1, ER);
		rd(6'h01, d, r);
		`CHK(r, ER);
		wr(pwm_pkg::T2_COUNT_IX, 8'h5A, 4'h1, OK);
		rdc(pwm_pkg::T2_COUNT_IX, 8'h00, OK);
		rdc(pwm_pkg::T2_BOUND_IX, 8'h00, OK);
		rdc(pwm_pkg::T2_SCALE_IX, 8'h00, OK);
		rdc(pwm_pkg::T3_COUNT_IX, 8'h00, OK);
		rdc(pwm_pkg::T3_SCALE_IX, 8'h00, OK);
		for (i = 0; i < 10; i++) edges(codes[i], lns[i]);
		duty(2, 8'h16, 8'h00, 8'h00);
		duty(3, 8'h1F, 8'h00, 8'hFF);
		duty(2, 8'h12, 8'h00, 8'h80);
		duty(3, 8'h1A, 8'hE0, 8'h7F);
		duty(2, 8'h1C, 8'h1F, 8'h40);
		duty(2, 8'h1B, 8'h40, 8'h30);
		for (i = 0; i < 6; i++) begin
			v = rnd();
			c = {4'h1, v[3:0]};
			v = rnd();
			s = {v[7], 1'b0, v[6], 3'b000, v[1:0]};
			b = rnd();
			if (!c[1]) b = b & 8'h1F;
			duty(2 + i % 2, c, s, b);
		end
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		rdc(pwm_pkg::T3_CTRL_IX, 8'h00, OK);
		tally_and_finish();
	end
endmodule
